// [rtl/pjts_map.svh]
// Purpose: named offsets, field positions, limits and times for the paper jam and toner supervisor
// Assumes: 200 MHz pclk, distances in tenths of a millimetre, times in milliseconds
// Notes: definitions only
`ifndef PJTS_MAP_SVH
`define PJTS_MAP_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define PJTS_ADDR_CTRL 12'h000
`define PJTS_ADDR_STATUS 12'h004
`define PJTS_ADDR_TOTAL 12'h008
`define PJTS_ADDR_LIFE 12'h00C

// ----------------------------------------
// control field positions
// ----------------------------------------
`define PJTS_CTRL_LIFE_RST 0
`define PJTS_CTRL_TOTAL_RST 1

// ----------------------------------------
// status field positions
// ----------------------------------------
`define PJTS_ST_INLET 0
`define PJTS_ST_FEED 1
`define PJTS_ST_OUTLET 2
`define PJTS_ST_SIZE 3
`define PJTS_ST_TLOW 4
`define PJTS_ST_TALARM 5
`define PJTS_ST_DABSENT 6
`define PJTS_ST_TSERIOUS 7
`define PJTS_ST_HALT 8
`define PJTS_ST_WSTOP 9
`define PJTS_ST_COVER 10

// ----------------------------------------
// paper travel limits, tenths of a mm
// ----------------------------------------
`define PJTS_STEP_DMM 13'h0005
`define PJTS_LIM_HOP 13'h0418
`define PJTS_LIM_FEED 13'h0595
`define PJTS_LIM_SIZE 13'h0FA6
`define PJTS_LIM_OUTLET 13'h1168
`define PJTS_HOP_TRIES 2'h3

// ----------------------------------------
// times
// ----------------------------------------
`define PJTS_CLK_KHZ 200000
`define PJTS_TICK_MS 40
`define PJTS_T_LOW_MS 640
`define PJTS_T_FULL_MS 280
`define PJTS_T_ROT_MS 2500
`define PJTS_T_DET_MS 3040

// ----------------------------------------
// drum counter thresholds
// ----------------------------------------
`define PJTS_DRUM_MIN 16'h001F
`define PJTS_LIFE_QUIET 16'h0064
`define PJTS_RESET_ZERO 16'h0000

`endif

// [rtl/pjts_pkg.sv]
// Purpose: types shared by the paper jam and toner supervisor
// Assumes: pjts_map.svh supplies all numbers
// Notes: state of the block is one packed struct
`include "pjts_map.svh"

package pjts_pkg;

	// ----------------------------------------
	// sensor and mechanism inputs
	// ----------------------------------------
	typedef struct packed {
		logic manual;
		logic paper;
		logic outlet;
		logic toner;
		logic cover_open_notice;
		logic drum_run;
		logic clutch;
		logic step;
	} pjts_sens_t;

	typedef enum logic [0:0] {
		PJTS_CV_SHUT = 1'b0,
		PJTS_CV_OPEN = 1'b1
	} pjts_cov_t;

	typedef enum logic [1:0] {
		PJTS_DC_IDLE = 2'b00,
		PJTS_DC_WAIT = 2'b01,
		PJTS_DC_DONE = 2'b11
	} pjts_dc_t;

	// ----------------------------------------
	// whole block state
	// ----------------------------------------
	typedef struct packed {
		pjts_sens_t s1;
		pjts_sens_t s2;
		pjts_sens_t s3;
		logic [1:0] boot;
		logic [22:0] tick_cnt;
		logic tick;
		logic [12:0] d_hop;
		logic [12:0] d_feed;
		logic [12:0] d_size;
		logic [12:0] d_out;
		logic hop_live;
		logic feed_live;
		logic size_live;
		logic out_live;
		logic [1:0] hop_cnt;
		logic inlet_jam;
		logic feed_jam;
		logic outlet_jam;
		logic size_err;
		pjts_cov_t cov;
		logic t_prev;
		logic [6:0] stable_cnt;
		logic [6:0] pulse_cnt;
		logic last_low;
		logic last_full;
		logic toner_low;
		logic toner_alarm;
		pjts_dc_t dc;
		logic [6:0] win_cnt;
		logic dc_power;
		logic drum_absent;
		logic toner_serious;
		logic warmup_stop;
		logic halt_print;
		logic [15:0] total_cnt;
		logic [15:0] life_cnt;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} pjts_state_t;

endpackage

// [rtl/pjts_top.sv]
// Purpose: paper path jam supervision, toner sensor evaluation and drum unit check, APB register access
// Assumes: all mechanism inputs asynchronous to pclk; one step pulse per motor step of fixed travel
// Notes: status kept in flip-flops only, lost at reset
//
// Notes on behaviour
// - at power-on, manual feed sensor alone seeing paper gives an inlet jam
// - inlet jam when paper misses paper sensor after three hops, limit 69.8+35 mm
// - feed jam when outlet sensor not reached within 122.9+20 mm of paper sensor
// - outlet jam when trailing edge stays on outlet sensor beyond L plus tolerance
// - size error when trailing edge stays on paper sensor beyond L of 400.6 mm
// - paper watched always; any jam halts printing until cover opened, cleared, closed
// - toner sampled every 40 ms; two low readings in a row set toner low
// - two full readings in a row clear toner low
// - no sensor change for two rotation cycles raises the toner sensor alarm
// - no toner evaluation while the drum is stopped
// - toner low suppressed while drum life counter reads 1 to 100
// - rotation 2.5 s; pulse over 0.64 s is low, 0.28 to 0.64 s is full
// - cover-open signal from the switch starts cover-open handling
// - no toner change soon after power-on or cover close means no drum unit
// - detection window 3.04 s as whole 40 ms samples, fraction dropped
// - drum-absent only with total count 31 or more, else serious sensor error
// - drum-absent cleared by cover open then close
// - drum-absent found at power-on with count 31 or more still allows printing
// - sensor error and drum-absent live only in volatile flip-flops
// - drum-absent and serious error are entered only around cover events or power-on
`timescale 1ns/1ps

module pjts_top
	import pjts_pkg::*;
#(
	parameter int TICK_CYCLES = `PJTS_TICK_MS * `PJTS_CLK_KHZ
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// mechanism pins
	input wire pjts_sens_t sens,
	// engine controls
	output logic halt_print,
	output logic warmup_stop,
	output logic toner_low
);

	// ----------------------------------------
	// derived sample counts
	// ----------------------------------------
	localparam logic [6:0] LOW_TK = 7'(`PJTS_T_LOW_MS / `PJTS_TICK_MS);
	localparam logic [6:0] FULL_TK = 7'(`PJTS_T_FULL_MS / `PJTS_TICK_MS);
	localparam logic [6:0] ALARM_TK = 7'((2 * `PJTS_T_ROT_MS) / `PJTS_TICK_MS);
	localparam logic [6:0] DET_TK = 7'(`PJTS_T_DET_MS / `PJTS_TICK_MS);
	localparam logic [22:0] TICK_LAST = 23'(TICK_CYCLES - 1);

	pjts_state_t q_r;
	pjts_state_t q_nxt;

	logic [31:0] status_w;
	logic step_ev;
	logic clutch_rise;
	logic paper_rise;
	logic paper_fall;
	logic outlet_rise;
	logic outlet_fall;
	logic cover_rise;
	logic cover_fall;
	logic t_now;
	logic apb_setup;
	logic apb_write;
	logic quiet;

	// ----------------------------------------
	// status word
	// ----------------------------------------
	always_comb begin
		status_w = 32'h0000_0000;
		status_w[`PJTS_ST_INLET] = q_r.inlet_jam;
		status_w[`PJTS_ST_FEED] = q_r.feed_jam;
		status_w[`PJTS_ST_OUTLET] = q_r.outlet_jam;
		status_w[`PJTS_ST_SIZE] = q_r.size_err;
		status_w[`PJTS_ST_TLOW] = q_r.toner_low;
		status_w[`PJTS_ST_TALARM] = q_r.toner_alarm;
		status_w[`PJTS_ST_DABSENT] = q_r.drum_absent;
		status_w[`PJTS_ST_TSERIOUS] = q_r.toner_serious;
		status_w[`PJTS_ST_HALT] = q_r.halt_print;
		status_w[`PJTS_ST_WSTOP] = q_r.warmup_stop;
		status_w[`PJTS_ST_COVER] = (q_r.cov == PJTS_CV_OPEN);
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		q_nxt = q_r;

		// edges seen only on the second and third stages, never on the first
		q_nxt.s1 = sens;
		q_nxt.s2 = q_r.s1;
		q_nxt.s3 = q_r.s2;
		step_ev = q_r.s2.step & ~q_r.s3.step;
		clutch_rise = q_r.s2.clutch & ~q_r.s3.clutch;
		paper_rise = q_r.s2.paper & ~q_r.s3.paper;
		paper_fall = ~q_r.s2.paper & q_r.s3.paper;
		outlet_rise = q_r.s2.outlet & ~q_r.s3.outlet;
		outlet_fall = ~q_r.s2.outlet & q_r.s3.outlet;
		cover_rise = q_r.s2.cover_open_notice & ~q_r.s3.cover_open_notice;
		cover_fall = ~q_r.s2.cover_open_notice & q_r.s3.cover_open_notice;
		t_now = q_r.s2.toner;
		apb_setup = psel & ~penable;
		apb_write = psel & penable & pwrite & q_r.pready;
		quiet = (q_r.life_cnt != `PJTS_RESET_ZERO) && (q_r.life_cnt <= `PJTS_LIFE_QUIET);

		q_nxt.tick = 1'b0;
		if (q_r.tick_cnt == TICK_LAST) begin
			q_nxt.tick_cnt = '0;
			q_nxt.tick = 1'b1;
		end else begin
			q_nxt.tick_cnt = q_r.tick_cnt + 23'h000001;
		end

		if (step_ev) begin
			if (q_r.hop_live && q_r.d_hop != 13'h1FFF) q_nxt.d_hop = q_r.d_hop + `PJTS_STEP_DMM;
			if (q_r.feed_live && q_r.d_feed != 13'h1FFF) q_nxt.d_feed = q_r.d_feed + `PJTS_STEP_DMM;
			if (q_r.size_live && q_r.d_size != 13'h1FFF) q_nxt.d_size = q_r.d_size + `PJTS_STEP_DMM;
			if (q_r.out_live && q_r.d_out != 13'h1FFF) q_nxt.d_out = q_r.d_out + `PJTS_STEP_DMM;
		end

		// jams are cleared first so a jam found in the same cycle still wins
		// cover opened, paper removed, cover closed releases the halt
		unique case (q_r.cov)
			PJTS_CV_SHUT: begin
				if (cover_rise) q_nxt.cov = PJTS_CV_OPEN;
			end
			PJTS_CV_OPEN: begin
				if (cover_fall) begin
					q_nxt.cov = PJTS_CV_SHUT;
					if (~q_r.s2.paper & ~q_r.s2.outlet & ~q_r.s2.manual) begin
						q_nxt.inlet_jam = 1'b0;
						q_nxt.feed_jam = 1'b0;
						q_nxt.outlet_jam = 1'b0;
						q_nxt.size_err = 1'b0;
						q_nxt.hop_cnt = 2'h0;
					end
				end
			end
		endcase

		// reset release taken as power-on after the synchronisers fill
		if (q_r.boot != 2'h3) q_nxt.boot = q_r.boot + 2'h1;
		// manual feed sensor alone at power-on
		if (q_r.boot == 2'h2 && q_r.s2.manual && ~q_r.s2.paper && ~q_r.s2.outlet) q_nxt.inlet_jam = 1'b1;

		// three hops without reaching the paper sensor
		if (clutch_rise) begin
			q_nxt.hop_live = 1'b1;
			q_nxt.d_hop = '0;
			if (q_r.hop_cnt != `PJTS_HOP_TRIES) q_nxt.hop_cnt = q_r.hop_cnt + 2'h1;
		end else if (paper_rise) begin
			q_nxt.hop_live = 1'b0;
			q_nxt.hop_cnt = 2'h0;
		end else if (q_r.hop_live && q_r.d_hop > `PJTS_LIM_HOP) begin
			q_nxt.hop_live = 1'b0;
			if (q_r.hop_cnt == `PJTS_HOP_TRIES) q_nxt.inlet_jam = 1'b1;
		end

		// paper sensor to outlet sensor travel
		if (paper_rise) begin
			q_nxt.feed_live = 1'b1;
			q_nxt.d_feed = '0;
		end else if (outlet_rise) begin
			q_nxt.feed_live = 1'b0;
		end else if (q_r.feed_live && q_r.d_feed > `PJTS_LIM_FEED) begin
			q_nxt.feed_live = 1'b0;
			q_nxt.feed_jam = 1'b1;
		end

		// sheet length under the paper sensor
		if (paper_rise) begin
			q_nxt.size_live = 1'b1;
			q_nxt.d_size = '0;
		end else if (paper_fall) begin
			q_nxt.size_live = 1'b0;
		end else if (q_r.size_live && q_r.d_size > `PJTS_LIM_SIZE) begin
			q_nxt.size_live = 1'b0;
			q_nxt.size_err = 1'b1;
		end

		// sheet length under the outlet sensor
		if (outlet_rise) begin
			q_nxt.out_live = 1'b1;
			q_nxt.d_out = '0;
		end else if (outlet_fall) begin
			q_nxt.out_live = 1'b0;
		end else if (q_r.out_live && q_r.d_out > `PJTS_LIM_OUTLET) begin
			q_nxt.out_live = 1'b0;
			q_nxt.outlet_jam = 1'b1;
		end

		// ejected sheets advance the drum counters
		if (outlet_fall) begin
			if (q_r.total_cnt != 16'hFFFF) q_nxt.total_cnt = q_r.total_cnt + 16'h0001;
			if (q_r.life_cnt != 16'hFFFF) q_nxt.life_cnt = q_r.life_cnt + 16'h0001;
		end

		// toner sensor evaluated only on ticks with the drum turning
		if (q_r.tick && q_r.s2.drum_run) begin
			q_nxt.t_prev = t_now;
			// unchanged output counts toward the alarm
			if (t_now != q_r.t_prev) begin
				q_nxt.stable_cnt = '0;
				q_nxt.toner_alarm = 1'b0;
			end else if (q_r.stable_cnt != 7'h7F) begin
				q_nxt.stable_cnt = q_r.stable_cnt + 7'h01;
				if (q_r.stable_cnt + 7'h01 >= ALARM_TK) q_nxt.toner_alarm = 1'b1;
			end
			if (t_now && q_r.pulse_cnt != 7'h7F) q_nxt.pulse_cnt = q_r.pulse_cnt + 7'h01;
			if (~t_now && q_r.t_prev) begin
				q_nxt.pulse_cnt = '0;
				if (q_r.pulse_cnt > LOW_TK) begin
					q_nxt.last_low = 1'b1;
					q_nxt.last_full = 1'b0;
					if (q_r.last_low && !quiet) q_nxt.toner_low = 1'b1;
				end else if (q_r.pulse_cnt > FULL_TK && q_r.pulse_cnt < LOW_TK) begin
					q_nxt.last_full = 1'b1;
					q_nxt.last_low = 1'b0;
					if (q_r.last_full) q_nxt.toner_low = 1'b0;
				end else begin
					q_nxt.last_low = 1'b0;
					q_nxt.last_full = 1'b0;
				end
			end
		end

		// drum unit check after power-on or cover close
		unique case (q_r.dc)
			PJTS_DC_IDLE: begin
				if (q_r.boot == 2'h2) begin
					q_nxt.dc = PJTS_DC_WAIT;
					q_nxt.dc_power = 1'b1;
					q_nxt.win_cnt = '0;
					q_nxt.stable_cnt = '0;
				end
			end
			PJTS_DC_WAIT: begin
				if (q_r.tick && q_r.s2.drum_run) begin
					q_nxt.win_cnt = q_r.win_cnt + 7'h01;
					if (q_r.win_cnt + 7'h01 == DET_TK) begin
						q_nxt.dc = PJTS_DC_DONE;
						if (q_r.stable_cnt + 7'h01 >= DET_TK && t_now == q_r.t_prev) begin
							if (q_r.total_cnt >= `PJTS_DRUM_MIN) q_nxt.drum_absent = 1'b1;
							else q_nxt.toner_serious = 1'b1;
						end
					end
				end
			end
			PJTS_DC_DONE: begin
			end
			default: begin
				q_nxt.dc = PJTS_DC_IDLE;
			end
		endcase
		// cover close after refitting clears and re-arms
		if (cover_fall) begin
			q_nxt.drum_absent = 1'b0;
			q_nxt.toner_serious = 1'b0;
			q_nxt.dc = PJTS_DC_WAIT;
			q_nxt.dc_power = 1'b0;
			q_nxt.win_cnt = '0;
			q_nxt.stable_cnt = '0;
		end

		// power-on drum-absent keeps the engine printable
		q_nxt.warmup_stop = q_r.toner_serious | (q_r.drum_absent & ~q_r.dc_power);
		q_nxt.halt_print = q_r.inlet_jam | q_r.feed_jam | q_r.outlet_jam | q_r.size_err;

		// apb: answer in the first access cycle
		q_nxt.pready = apb_setup;
		q_nxt.pslverr = 1'b0;
		if (apb_setup) begin
			q_nxt.prdata = 32'h0000_0000;
			unique case (paddr)
				`PJTS_ADDR_CTRL: q_nxt.prdata = 32'h0000_0000;
				`PJTS_ADDR_STATUS: q_nxt.prdata = status_w;
				`PJTS_ADDR_TOTAL: q_nxt.prdata = {16'h0000, q_r.total_cnt};
				`PJTS_ADDR_LIFE: q_nxt.prdata = {16'h0000, q_r.life_cnt};
				default: q_nxt.pslverr = 1'b1;
			endcase
		end
		if (apb_write) begin
			unique case (paddr)
				`PJTS_ADDR_CTRL: begin
					if (pwdata[`PJTS_CTRL_LIFE_RST]) q_nxt.life_cnt = `PJTS_RESET_ZERO;
					if (pwdata[`PJTS_CTRL_TOTAL_RST]) q_nxt.total_cnt = `PJTS_RESET_ZERO;
				end
				`PJTS_ADDR_TOTAL: q_nxt.total_cnt = pwdata[15:0];
				`PJTS_ADDR_LIFE: q_nxt.life_cnt = pwdata[15:0];
				default: begin
				end
			endcase
		end
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	// volatile only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q_r <= '0;
		end else begin
			q_r <= q_nxt;
		end
	end

	assign prdata = q_r.prdata;
	assign pready = q_r.pready;
	assign pslverr = q_r.pslverr;
	assign halt_print = q_r.halt_print;
	assign warmup_stop = q_r.warmup_stop;
	assign toner_low = q_r.toner_low;

endmodule

// [dv/pjts_top_assertions.sv]
// Purpose: port checker for pjts_top
// Assumes: apb master keeps setup then access order
// Notes: ages saturate so a long quiet spell never wraps
`timescale 1ns/1ps
module pjts_top_chk
	import pjts_pkg::*;
#(
	parameter int TICK_CYCLES = 20
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// pins
	input wire pjts_sens_t sens,
	input wire logic halt_print,
	input wire logic warmup_stop,
	input wire logic toner_low
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [4:0] cov_age_r, drum_age_r;
	logic cov_seen_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cov_age_r <= 5'h1F;
			drum_age_r <= 5'h1F;
			cov_seen_r <= 1'b0;
		end else begin
			cov_age_r <= sens.cover_open_notice ? 5'h00 : cov_age_r + 5'(cov_age_r != 5'h1F);
			drum_age_r <= sens.drum_run ? 5'h00 : drum_age_r + 5'(drum_age_r != 5'h1F);
			cov_seen_r <= cov_seen_r | sens.cover_open_notice;
		end
	end
	// ----------------
	// properties
	// ----------------
	sequence s_setup; psel && !penable; endsequence
	sequence s_access; psel && penable; endsequence
	property p_walk; s_setup ##1 s_access |-> pready; endproperty
	a_walk: assert property (p_walk) else $error("no ready in access cycle");
	property p_cause; pready |-> $past(psel && !penable) ##1 !pready; endproperty
	a_cause: assert property (p_cause) else $error("ready without setup or too long");
	property p_unmap; (psel && !penable && paddr > 12'h00C) |=> pslverr && prdata == 32'h0; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped access not refused");
	property p_map; (psel && !penable && paddr <= 12'h00C && paddr[1:0] == 2'h0) |=> pready && !pslverr; endproperty
	a_map: assert property (p_map) else $error("mapped access refused");
	property p_ctrl; (psel && !penable && !pwrite && paddr == 12'h000) |=> prdata == 32'h0; endproperty
	a_ctrl: assert property (p_ctrl) else $error("control word reads nonzero");
	property p_halt; $fell(halt_print) |-> cov_age_r < 5'h10; endproperty
	a_halt: assert property (p_halt) else $error("halt left without cover cycle");
	property p_tlow; $rose(toner_low) |-> drum_age_r < 5'h10; endproperty
	a_tlow: assert property (p_tlow) else $error("toner low set with drum stopped");
	property p_warm; $rose(warmup_stop) |-> cov_seen_r; endproperty
	a_warm: assert property (p_warm) else $error("warmup stop without cover event");
endmodule

bind pjts_top pjts_top_chk #(.TICK_CYCLES(TICK_CYCLES)) chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.sens(sens), .halt_print(halt_print), .warmup_stop(warmup_stop), .toner_low(toner_low));

// [dv/pjts_mech.sv]
// Purpose: printer mechanism model driving the sensor pins
// Assumes: levels change just after a rising edge
// Notes: bench may also set single levels in lv
`timescale 1ns/1ps
module pjts_mech
	import pjts_pkg::*;
#(
	parameter int TICK = 20
) (
	// clock
	input wire logic pclk,
	// sensor pins
	output pjts_sens_t sens
);
	pjts_sens_t lv;
	// pins idle low until a task or the bench moves them
	initial lv = '0;
	assign sens = lv;
	// each level held three clocks so the synchroniser cannot miss it
	task automatic steps(input int n);
		repeat (n) begin
			@(posedge pclk);
			lv.step <= 1'b1;
			repeat (3) @(posedge pclk);
			lv.step <= 1'b0;
			repeat (2) @(posedge pclk);
		end
	endtask
	task automatic hop(input int n);
		@(posedge pclk);
		lv.clutch <= 1'b1;
		steps(n);
		lv.clutch <= 1'b0;
		repeat (4) @(posedge pclk);
	endtask
	task automatic cover_cycle();
		@(posedge pclk);
		lv.cover_open_notice <= 1'b1;
		repeat (8) @(posedge pclk);
		lv.manual <= 1'b0;
		lv.paper <= 1'b0;
		lv.outlet <= 1'b0;
		repeat (8) @(posedge pclk);
		lv.cover_open_notice <= 1'b0;
		repeat (8) @(posedge pclk);
	endtask
	task automatic toner_pulse(input int hi, input int lo);
		@(posedge pclk);
		lv.toner <= 1'b1;
		repeat (hi * TICK) @(posedge pclk);
		lv.toner <= 1'b0;
		repeat (lo * TICK) @(posedge pclk);
	endtask
endmodule

// [dv/pjts_top_tb.sv]
// Purpose: self-checking bench for pjts_top
// Assumes: a tick of 20 clocks stands in for 40 ms
// Notes: status words written as hex literals, not built from the field map
`timescale 1ns/1ps
module pjts_top_tb;
	import pjts_pkg::*;
	localparam int TK = 20;
	logic pclk, presetn, psel, penable, pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic pready, pslverr, err, halt_print, warmup_stop, toner_low;
	pjts_sens_t sens;
	int n_mismatch = 0, total_checks = 0;
	always #2.5 pclk = (pclk !== 1'b1);
	pjts_top #(.TICK_CYCLES(TK)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sens(sens), .halt_print(halt_print), .warmup_stop(warmup_stop), .toner_low(toner_low));
	pjts_mech #(.TICK(TK)) mech (.pclk(pclk), .sens(sens));
	// ----------------
	// tasks
	// ----------------
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("FAIL %s exp %h seen %h", n, exp, seen);
		end
	endtask
	// request held until pready is seen at a rising edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (i == 20) begin
			n_mismatch++;
			report_and_stop();
		end
	endtask
	task automatic rchk(input string n, input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(n, rd, e);
	endtask
	task automatic st(input logic [31:0] e);
		repeat (6) @(posedge pclk);
		rchk("status", 12'h004, e);
	endtask
	initial begin
		repeat (100000) @(posedge pclk);
		n_mismatch++;
		report_and_stop();
	end
	// ----------------
	// scenarios
	// ----------------
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		@(posedge pclk);
		mech.lv.manual <= 1'b1;
		repeat (11) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 12'h010, 32'h0);
		chk("slverr", 32'(err), 32'h1);
		chk("unmapped", rd, 32'h0);
		st(32'h101);
		chk("halt", 32'(halt_print), 32'h1);
		mech.cover_cycle();
		st(32'h0);
		rchk("ctrl", 12'h000, 32'h0);
		rchk("total", 12'h008, 32'h0);
		rchk("life", 12'h00C, 32'h0);
		mech.hop(210);
		mech.hop(210);
		st(32'h0);
		mech.hop(210);
		st(32'h101);
		mech.cover_cycle();
		@(posedge pclk);
		mech.lv.paper <= 1'b1;
		mech.steps(285);
		st(32'h0);
		mech.steps(2);
		st(32'h102);
		mech.cover_cycle();
		// clean page counted once on outlet release
		@(posedge pclk);
		mech.lv.paper <= 1'b1;
		mech.steps(10);
		mech.lv.outlet <= 1'b1;
		mech.steps(100);
		mech.lv.paper <= 1'b0;
		mech.steps(2);
		mech.lv.outlet <= 1'b0;
		st(32'h0);
		rchk("total", 12'h008, 32'h1);
		rchk("life", 12'h00C, 32'h1);
		apb(1'b1, 12'h000, 32'h1);
		rchk("life", 12'h00C, 32'h0);
		rchk("total", 12'h008, 32'h1);
		@(posedge pclk);
		mech.lv.paper <= 1'b1;
		mech.steps(10);
		mech.lv.outlet <= 1'b1;
		mech.steps(791);
		st(32'h0);
		mech.steps(1);
		st(32'h108);
		mech.steps(100);
		st(32'h10C);
		mech.cover_cycle();
		// life count now 1, so low stays hidden
		@(posedge pclk);
		mech.lv.drum_run <= 1'b1;
		repeat (2) mech.toner_pulse(20, 5);
		chk("toner_low", 32'(toner_low), 32'h0);
		apb(1'b1, 12'h00C, 32'h65);
		repeat (2) mech.toner_pulse(20, 5);
		st(32'h10);
		chk("toner_low", 32'(toner_low), 32'h1);
		repeat (2) mech.toner_pulse(10, 5);
		st(32'h0);
		mech.lv.drum_run <= 1'b0;
		repeat (2) mech.toner_pulse(20, 5);
		st(32'h0);
		apb(1'b1, 12'h008, 32'h1E);
		rchk("total", 12'h008, 32'h1E);
		mech.cover_cycle();
		@(posedge pclk);
		mech.lv.drum_run <= 1'b1;
		repeat (70 * TK) @(posedge pclk);
		st(32'h0);
		repeat (10 * TK) @(posedge pclk);
		st(32'h280);
		chk("warmup", 32'(warmup_stop), 32'h1);
		apb(1'b1, 12'h008, 32'h1F);
		mech.cover_cycle();
		repeat (130 * TK) @(posedge pclk);
		st(32'h260);
		chk("warmup", 32'(warmup_stop), 32'h1);
		mech.toner_pulse(10, 5);
		mech.cover_cycle();
		st(32'h0);
		chk("warmup", 32'(warmup_stop), 32'h0);
		// second power-on in mid-run: drum turning, sensor frozen, total raised to 31 inside the window
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		rchk("total", 12'h008, 32'h0);
		apb(1'b1, 12'h008, 32'h1F);
		repeat (80 * TK) @(posedge pclk);
		st(32'h40);
		chk("warmup", 32'(warmup_stop), 32'h0);
		report_and_stop();
	end
endmodule
